// File: logic/pin_sync_edge.v
`timescale 1ns/100ps
// Two-stage synchroniser per bit with edge detection on the settled level
module pin_sync_edge #(
	parameter WIDTH = 1
) (
	input wire sys_clk,
	input wire sys_rst,
	input wire clk_en,
	input wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] level_out,
	output wire [WIDTH-1:0] rise_out,
	output wire [WIDTH-1:0] fall_out
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			reg meta_q;
			reg sync_q;
			reg prev_q;
			// Not reset, so straps already settle while reset is held
			always @(posedge sys_clk) begin
				if (clk_en) begin
					meta_q <= async_in[i];
					sync_q <= meta_q;
				end
			end
			always @(posedge sys_clk) begin
				if (sys_rst) begin
					prev_q <= 1'b0;
				end else if (clk_en) begin
					prev_q <= sync_q;
				end
			end
			assign level_out[i] = sync_q;
			assign rise_out[i] = clk_en & sync_q & ~prev_q;
			assign fall_out[i] = clk_en & ~sync_q & prev_q;
		end
	endgenerate

endmodule // pin_sync_edge

// File: logic/sysctl_clock_source_select.v
// Local design decisions: the register offsets and the AHB-Lite slave port.
`timescale 1ns/100ps
`include "sysctl_defs.vh"

// How it works
// - Edge field: off, rising, falling, both
// - Tick period 2^10 to 2^13 source periods
// - Watchdog off only with option off, key 1010
// - Forced option keeps watchdog on, key ignored
// - Fast RC frequency fixed by option: 4/8/12
// - Slow crystal allowed only with fast RC
// - External RC takes line6, line5 stays I/O
// - Fast RC frees line5 and line6 unless the slow crystal is used, which frees neither
// - Five sources; clocks feed watchdog, time base
// - Slow crystal independent of system clock
// - Mode bit picks slow crystal, stops fast RC
// - Slow crystal keeps running during halt
module sysctl_clock_source_select (
	input wire sys_clk,
	input wire sys_rst,
	input wire clk_en,
	input wire hsel,
	input wire [7:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg hreadyout,
	output reg [31:0] hrdata,
	output reg hresp,
	input wire [1:0] fast_osc_cfg,
	input wire slow_lxt_cfg,
	input wire [1:0] fast_internal_rc_osc_freq_cfg,
	input wire wdt_force_cfg,
	input wire ext_int_pin,
	input wire lxt_clk_pin,
	input wire slow_internal_rc_osc_clk_pin,
	input wire halt_req,
	output reg irq_q,
	output reg ext_int_pulse_q,
	output reg tick_pulse_q,
	output reg watchdog_run_q,
	output reg wdt_clk_lxt_q,
	output reg [1:0] fast_internal_rc_osc_freq_sel_q,
	output reg fast_osc_run_q,
	output reg lxt_run_q,
	output reg sysclk_src_slow_q,
	output reg porta_line5_free_q,
	output reg porta_line6_free_q,
	output reg config_error_q
);

	localparam CFG_W = 6;

	// Synchronised straps and pins
	wire [CFG_W-1:0] cfg_sync;
	wire [2:0] pin_level;
	wire [2:0] pin_rise;
	wire [2:0] pin_fall;

	pin_sync_edge #(
		.WIDTH(CFG_W)
	) u_cfg_sync (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.async_in({wdt_force_cfg, fast_internal_rc_osc_freq_cfg, slow_lxt_cfg, fast_osc_cfg}),
		.level_out(cfg_sync),
		.rise_out(),
		.fall_out()
	);

	pin_sync_edge #(
		.WIDTH(3)
	) u_pin_sync (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.async_in({slow_internal_rc_osc_clk_pin, lxt_clk_pin, ext_int_pin}),
		.level_out(pin_level),
		.rise_out(pin_rise),
		.fall_out(pin_fall)
	);

	// Option snapshot
	reg [1:0] fast_cfg_q;
	reg lxt_cfg_q;
	reg [1:0] freq_cfg_q;
	reg wdt_force_q;
	reg err_pend_q;

	// Software registers
	reg [7:0] sc2_q;
	reg slow_sel_q;
	reg [`IRQ_W-1:0] irq_stat_q;
	reg [`IRQ_W-1:0] irq_mask_q;
	reg [`TICK_CNT_W-1:0] tick_cnt_q;

	// Bus data phase
	reg wr_pend_q;
	reg [7:0] wr_addr_q;

	// Decoded option view
	wire fast_reserved = (fast_cfg_q == `FAST_RESERVED);
	wire [1:0] fast_eff = fast_reserved ? `FAST_INT_RC : fast_cfg_q;
	wire lxt_ok = lxt_cfg_q & (fast_eff == `FAST_INT_RC);
	wire cfg_bad = fast_reserved | (lxt_cfg_q & ~lxt_ok) | (freq_cfg_q == 2'h3);
	wire slow_eff = lxt_ok & slow_sel_q;

	// Pins released for I/O as {line6, line5}
	function [1:0] pins_free;
		input [1:0] fast;
		input slow_crystal_osc;
		begin
			if (slow_crystal_osc) begin
				pins_free = 2'b00;
			end else begin
				case (fast)
					`FAST_CRYSTAL: pins_free = 2'b00;
					`FAST_EXT_RC: pins_free = 2'b01;
					`FAST_INT_RC: pins_free = 2'b11;
					default: pins_free = 2'b11;
				endcase
			end
		end
	endfunction

	// Low bits that must all be one before the counter wraps a period
	function [`TICK_CNT_W-1:0] tick_mask;
		input [1:0] sel;
		begin
			case (sel)
				2'h0: tick_mask = 13'h03ff;
				2'h1: tick_mask = 13'h07ff;
				2'h2: tick_mask = 13'h0fff;
				default: tick_mask = 13'h1fff;
			endcase
		end
	endfunction

	// Slow crystal edges when present, internal slow RC otherwise
	wire tick_src_edge = lxt_ok ? pin_rise[1] : pin_rise[2];
	wire [`TICK_CNT_W-1:0] cur_mask = tick_mask(sc2_q[`SC2_TICK_HI:`SC2_TICK_LO]);
	wire tick_d = tick_src_edge & ((tick_cnt_q & cur_mask) == cur_mask);

	reg ext_hit;
	always @* begin
		case (sc2_q[`SC2_EDGE_HI:`SC2_EDGE_LO])
			`EDGE_RISE: ext_hit = pin_rise[0];
			`EDGE_FALL: ext_hit = pin_fall[0];
			`EDGE_BOTH: ext_hit = pin_rise[0] | pin_fall[0];
			default: ext_hit = 1'b0;
		endcase
	end

	wire wdt_run_d = wdt_force_q | (sc2_q[`SC2_KEY_HI:`SC2_KEY_LO] != `WDT_OFF_KEY);
	wire [1:0] free_d = pins_free(fast_eff, lxt_ok);

	wire [11:0] clk_status = {
		fast_osc_run_q, lxt_ok, fast_eff, fast_internal_rc_osc_freq_sel_q, wdt_force_q,
		watchdog_run_q, sysclk_src_slow_q, porta_line5_free_q, porta_line6_free_q, config_error_q
	};

	function [31:0] rd_word;
		input [7:0] addr;
		input [7:0] sc2;
		input clkmode;
		input [11:0] cst;
		input [`IRQ_W-1:0] stat;
		input [`IRQ_W-1:0] mask;
		begin
			case (addr)
				`OFS_SYS_CTRL_SECOND: rd_word = {24'h00_0000, sc2};
				`OFS_CLK_MODE: rd_word = {31'h0000_0000, clkmode};
				`OFS_CLK_STATUS: rd_word = {20'h0_0000, cst};
				`OFS_IRQ_STATUS: rd_word = {29'h0000_0000, stat};
				`OFS_IRQ_MASK: rd_word = {29'h0000_0000, mask};
				default: rd_word = 32'h0000_0000;
			endcase
		end
	endfunction

	wire addr_take = hsel & hready & htrans[1];
	wire wr_hit = wr_pend_q & clk_en;

	// Events, and write-one-to-clear with set taking priority
	wire [`IRQ_W-1:0] ev = {err_pend_q & cfg_bad, tick_d, ext_hit};
	wire [`IRQ_W-1:0] w1c = (wr_hit && wr_addr_q == `OFS_IRQ_STATUS) ? hwdata[`IRQ_W-1:0] : {`IRQ_W{1'b0}};
	wire [`IRQ_W-1:0] stat_d = (irq_stat_q & ~w1c) | ev;
	wire [`IRQ_W-1:0] mask_d = (wr_hit && wr_addr_q == `OFS_IRQ_MASK) ? hwdata[`IRQ_W-1:0] : irq_mask_q;

	// Options are latched only while reset is held
	always @(posedge sys_clk) begin
		if (sys_rst && clk_en) begin
			fast_cfg_q <= cfg_sync[1:0];
			lxt_cfg_q <= cfg_sync[2];
			freq_cfg_q <= cfg_sync[4:3];
			wdt_force_q <= cfg_sync[5];
		end
	end

	// Bus slave: zero wait, read data captured at the address phase
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			hreadyout <= 1'b0;
			hrdata <= 32'h0000_0000;
			hresp <= 1'b0;
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else if (clk_en) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend_q <= addr_take & hwrite;
			if (addr_take) begin
				wr_addr_q <= {haddr[7:2], 2'b00};
				if (!hwrite) begin
					hrdata <= rd_word({haddr[7:2], 2'b00}, sc2_q, slow_sel_q, clk_status, irq_stat_q, irq_mask_q);
				end
			end
		end
	end

	// Software registers and interrupt state
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			sc2_q <= `SC2_RESET;
			slow_sel_q <= 1'b0;
			irq_stat_q <= {`IRQ_W{1'b0}};
			irq_mask_q <= {`IRQ_W{1'b0}};
			irq_q <= 1'b0;
			err_pend_q <= 1'b1;
		end else if (clk_en) begin
			if (wr_hit && wr_addr_q == `OFS_SYS_CTRL_SECOND) begin
				// Key still stored when forced, so software reads back what it wrote
				sc2_q <= hwdata[7:0];
			end
			if (wr_hit && wr_addr_q == `OFS_CLK_MODE) begin
				slow_sel_q <= hwdata[0];
			end
			err_pend_q <= 1'b0;
			irq_stat_q <= stat_d;
			irq_mask_q <= mask_d;
			irq_q <= |(stat_d & mask_d);
		end
	end

	// Time base runs on slow-clock edges and ignores halt
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			tick_cnt_q <= {`TICK_CNT_W{1'b0}};
			tick_pulse_q <= 1'b0;
			ext_int_pulse_q <= 1'b0;
		end else if (clk_en) begin
			if (tick_src_edge) begin
				tick_cnt_q <= tick_cnt_q + 13'h0001;
			end
			tick_pulse_q <= tick_d;
			ext_int_pulse_q <= ext_hit;
		end
	end

	// Clock routing outputs
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			watchdog_run_q <= 1'b1;
			wdt_clk_lxt_q <= 1'b0;
			fast_internal_rc_osc_freq_sel_q <= `FAST_INTERNAL_RC_OSC_4MHZ;
			fast_osc_run_q <= 1'b0;
			lxt_run_q <= 1'b0;
			sysclk_src_slow_q <= 1'b0;
			porta_line5_free_q <= 1'b0;
			porta_line6_free_q <= 1'b0;
			config_error_q <= 1'b0;
		end else if (clk_en) begin
			watchdog_run_q <= wdt_run_d;
			wdt_clk_lxt_q <= lxt_ok;
			fast_internal_rc_osc_freq_sel_q <= (freq_cfg_q == 2'h3) ? `FAST_INTERNAL_RC_OSC_4MHZ : freq_cfg_q;
			// Halt stops the fast source; slow selection also stops the fast RC
			fast_osc_run_q <= ~halt_req & ~slow_eff;
			lxt_run_q <= lxt_ok;
			sysclk_src_slow_q <= slow_eff;
			porta_line5_free_q <= free_d[0];
			porta_line6_free_q <= free_d[1];
			config_error_q <= cfg_bad;
		end
	end

endmodule // sysctl_clock_source_select

// File: logic/sysctl_defs.vh
`ifndef SYSCTL_DEFS_VH
`define SYSCTL_DEFS_VH

// Register byte addresses
`define OFS_SYS_CTRL_SECOND 8'h00
`define OFS_CLK_MODE 8'h04
`define OFS_CLK_STATUS 8'h08
`define OFS_IRQ_STATUS 8'h0c
`define OFS_IRQ_MASK 8'h10

// system_control_second layout and reset
`define SC2_RESET 8'h8a
`define SC2_EDGE_HI 7
`define SC2_EDGE_LO 6
`define SC2_TICK_HI 5
`define SC2_TICK_LO 4
`define SC2_KEY_HI 3
`define SC2_KEY_LO 0
`define WDT_OFF_KEY 4'ha

// External interrupt edge encodings
`define EDGE_OFF 2'h0
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h2
`define EDGE_BOTH 2'h3

// Fast oscillator option encodings
`define FAST_CRYSTAL 2'h0
`define FAST_EXT_RC 2'h1
`define FAST_INT_RC 2'h2
`define FAST_RESERVED 2'h3

// Internal fast RC frequency option encodings (4, 8, 12 MHz)
`define FAST_INTERNAL_RC_OSC_4MHZ 2'h0
`define FAST_INTERNAL_RC_OSC_8MHZ 2'h1
`define FAST_INTERNAL_RC_OSC_12MHZ 2'h2

// Tick period: 2^(TICK_EXP_BASE + select) source periods
`define TICK_EXP_BASE 10
`define TICK_CNT_W 13

// Interrupt status bits
`define IRQ_EXT_EDGE 0
`define IRQ_TICK 1
`define IRQ_CFG_ERR 2
`define IRQ_W 3

// Clock status bit positions
`define CST_CFG_ERR 0
`define CST_PA6_FREE 1
`define CST_PA5_FREE 2
`define CST_SLOW_SYSCLK 3
`define CST_WDT_RUN 4
`define CST_WDT_FORCE 5
`define CST_FREQ_LO 6
`define CST_FAST_LO 8
`define CST_LXT_OK 10
`define CST_FAST_RUN 11

`endif

// File: tb/osc_model.sv
`timescale 1ns/100ps
module osc_model #(
	parameter int HALF = 2
) (
	input wire logic sys_clk,
	output logic lxt_clk_pin,
	output logic slow_internal_rc_osc_clk_pin
);
	int cnt = 0;
	initial begin
		lxt_clk_pin = 1'b0;
		slow_internal_rc_osc_clk_pin = 1'b0;
	end
	// Both slow sources run free, even through halt
	always @(posedge sys_clk) begin
		cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
		if (cnt == HALF - 1) begin
			lxt_clk_pin <= ~lxt_clk_pin;
			slow_internal_rc_osc_clk_pin <= ~slow_internal_rc_osc_clk_pin;
		end
	end
endmodule // osc_model

// File: tb/sysctl_check_props.sv
`timescale 1ns/100ps
module sysctl_check (
	input wire sys_clk,
	input wire sys_rst,
	input wire [1:0] fast_osc_cfg,
	input wire slow_lxt_cfg,
	input wire wdt_force_cfg,
	input wire halt_req,
	input wire tick_pulse_q,
	input wire watchdog_run_q,
	input wire fast_osc_run_q,
	input wire lxt_run_q,
	input wire sysclk_src_slow_q,
	input wire porta_line5_free_q,
	input wire porta_line6_free_q,
	input wire config_error_q
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// Outputs show decoded routing only from the second edge after release
	logic up_q = 1'b0;
	always @(posedge sys_clk) up_q <= !sys_rst;
	wire lxt_ok = fast_osc_cfg == 2'h2 && slow_lxt_cfg;
	sequence halt_s;
		halt_req ##1 halt_req;
	endsequence
	sequence tick_s;
		tick_pulse_q ##1 !tick_pulse_q;
	endsequence
	wdt_force_a: assert property (up_q && wdt_force_cfg |-> watchdog_run_q)
		else $error("watchdog stopped while forced");
	lxt_reject_a: assert property (up_q && slow_lxt_cfg && fast_osc_cfg < 2'h2 |-> config_error_q && !lxt_run_q)
		else $error("slow crystal accepted with external fast source");
	lxt_accept_a: assert property (up_q && lxt_ok |-> lxt_run_q && !config_error_q)
		else $error("legal slow crystal not running");
	erc_pins_a: assert property (up_q && fast_osc_cfg == 2'h1 |-> porta_line5_free_q && !porta_line6_free_q)
		else $error("external RC pin use wrong");
	rc_pins_a: assert property (up_q && fast_osc_cfg == 2'h2 && !slow_lxt_cfg |-> porta_line5_free_q && porta_line6_free_q)
		else $error("internal RC did not free both lines");
	slow_sys_a: assert property (sysclk_src_slow_q |-> lxt_ok && !fast_osc_run_q)
		else $error("slow system clock in wrong state");
	halt_run_a: assert property (halt_s |-> !fast_osc_run_q && (lxt_run_q || !lxt_ok))
		else $error("halt state of oscillators wrong");
	tick_gap_a: assert property (tick_s |-> !tick_pulse_q [*7])
		else $error("ticks too close");
endmodule // sysctl_check

// File: tb/tb_sysctl_clock_source_select.sv
`timescale 1ns/100ps
module tb_sysctl_clock_source_select;
	logic sys_clk, sys_rst, clk_en, hsel, hwrite, hready, hreadyout, hresp, slow_lxt_cfg, wdt_force_cfg;
	logic ext_int_pin, lxt_clk_pin, slow_internal_rc_osc_clk_pin, halt_req, irq_q, ext_int_pulse_q, tick_pulse_q, watchdog_run_q;
	logic wdt_clk_lxt_q, fast_osc_run_q, lxt_run_q, sysclk_src_slow_q, porta_line5_free_q, porta_line6_free_q;
	logic config_error_q;
	logic [1:0] htrans, fast_osc_cfg, fast_internal_rc_osc_freq_cfg, fast_internal_rc_osc_freq_sel_q;
	logic [2:0] hsize;
	logic [7:0] haddr;
	logic [31:0] hwdata, hrdata, v;
	int errors = 0, check_count = 0, cyc = 0, n;
	// {ctrl byte, 0, watchdog on, rise seen, fall seen}
	logic [11:0] rows[6] = '{12'h0a0, 12'h456, 12'h8a1, 12'hca3, 12'hc07, 12'h0b4};
	// {fast, slow crystal, force, freq, line5 free, line6 free, error, freq seen}
	logic [10:0] straps[4] = '{11'h45a, 11'h394, 11'h021, 11'h6fc};
	assign clk_en = 1'b1;
	assign hsel = 1'b1;
	assign hsize = 3'h2;
	assign hready = hreadyout;
	sysctl_clock_source_select sysctl_clock_source_select_inst (.*);
	osc_model osc_model_inst (.sys_clk, .lxt_clk_pin, .slow_internal_rc_osc_clk_pin);
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	task automatic tk(input int k);
		repeat (k) @(posedge sys_clk);
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		v = hrdata;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic do_reset;
		sys_rst <= 1'b1;
		tk(16);
		sys_rst <= 1'b0;
		tk(3);
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 95000) begin
			errors++;
			final_report;
		end
	end
	initial begin
		sys_rst <= 1'b1;
		haddr <= 8'h00;
		htrans <= 2'h0;
		hwrite <= 1'b0;
		hwdata <= 32'h0000_0000;
		ext_int_pin <= 1'b0;
		halt_req <= 1'b0;
		{fast_osc_cfg, slow_lxt_cfg, fast_internal_rc_osc_freq_cfg, wdt_force_cfg} <= 6'b10_1_01_0;
		do_reset;
		chk(hresp, 1'b0);
		chk(wdt_clk_lxt_q, 1'b1);
		bus(1'b0, 8'h00, 0);
		chk(v, 32'h0000_008a);
		bus(1'b1, 8'h10, 32'h0000_0001);
		foreach (rows[i]) begin
			bus(1'b1, 8'h00, rows[i][11:4]);
			bus(1'b0, 8'h00, 0);
			chk(v, rows[i][11:4]);
			chk(watchdog_run_q, rows[i][2]);
			for (int e = 1; e >= 0; e--) begin
				ext_int_pin <= e[0];
				tk(6);
				bus(1'b0, 8'h0c, 0);
				chk(v[0], rows[i][e]);
				chk(irq_q, rows[i][e]);
				bus(1'b1, 8'h0c, 32'h0000_0001);
				tk(1);
				chk(irq_q, 1'b0);
			end
		end
		// Masked event stays pending, unmasking raises the line
		bus(1'b1, 8'h00, 32'h0000_004a);
		bus(1'b1, 8'h10, 0);
		ext_int_pin <= 1'b1;
		tk(6);
		chk(irq_q, 1'b0);
		bus(1'b1, 8'h10, 32'h0000_0001);
		tk(2);
		chk(irq_q, 1'b1);
		bus(1'b0, 8'h20, 0);
		chk(v, 0);
		bus(1'b1, 8'h04, 32'h0000_0001);
		tk(2);
		chk(sysclk_src_slow_q, 1'b1);
		bus(1'b1, 8'h04, 0);
		halt_req <= 1'b1;
		tk(3);
		chk(fast_osc_run_q, 1'b0);
		chk(lxt_run_q, 1'b1);
		halt_req <= 1'b0;
		foreach (rows[s]) if (s == 0 || s == 3) begin
			bus(1'b1, 8'h00, {s[1:0], 4'ha});
			@(posedge sys_clk iff tick_pulse_q);
			n = 0;
			do begin
				@(posedge sys_clk);
				n++;
			end while (tick_pulse_q !== 1'b1);
			chk(n, (1 << (10 + s)) * 4);
		end
		foreach (straps[i]) begin
			{fast_osc_cfg, slow_lxt_cfg, wdt_force_cfg, fast_internal_rc_osc_freq_cfg} <= straps[i][10:5];
			do_reset;
			chk({porta_line5_free_q, porta_line6_free_q, config_error_q}, straps[i][4:2]);
			chk(fast_internal_rc_osc_freq_sel_q, straps[i][1:0]);
			bus(1'b1, 8'h00, 32'h0000_000a);
			tk(2);
			chk(watchdog_run_q, straps[i][7]);
		end
		final_report;
	end
endmodule // tb_sysctl_clock_source_select

bind sysctl_clock_source_select sysctl_check sysctl_check_inst (.*);
